// >>> bench/cpu_seq_model.sv
// instruction sequencer stand-in driving the interrupt unit's cpu side
`timescale 1ns/100ps
`default_nettype none
module cpu_seq_model (
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic [2:0] instr_len,
   input  wire logic       return_from_interrupt_instr_cmd,
   input  wire logic       call_busy_q,
   output logic            last_cycle,
   output logic            return_from_interrupt_instr_exec
);
   logic [3:0] ph_q;
   logic [2:0] cnt_q;
   logic       pend_q;
   logic       issue;

   // ---------------------------------------------------------------
   // machine cycles and instruction ends
   // ---------------------------------------------------------------
   assign last_cycle = (cnt_q == instr_len - 3'h1) && !call_busy_q;
   assign issue = pend_q && (ph_q == 4'hb) && last_cycle;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ph_q <= 4'h0;
         cnt_q <= 3'h0;
         pend_q <= 1'b0;
         return_from_interrupt_instr_exec <= 1'b0;
      end else begin
         ph_q <= (ph_q == 4'hb) ? 4'h0 : ph_q + 4'h1;
         if (ph_q == 4'hb) begin
            cnt_q <= (call_busy_q || last_cycle) ? 3'h0 : cnt_q + 3'h1;
         end
         if (issue) begin
            pend_q <= 1'b0;
         end
         if (return_from_interrupt_instr_cmd) begin
            pend_q <= 1'b1;
         end
         return_from_interrupt_instr_exec <= issue;
      end
   end
endmodule // cpu_seq_model
`default_nettype wire

// >>> bench/four_level_vectored_interrupt_unit_bench.sv
// self-checking bench of the four-level vectored interrupt unit
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) \
   begin \
      cmp_count++; \
      if ((got) !== (exp)) begin \
         err_total++; \
         $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp); \
      end \
   end
module four_level_vectored_interrupt_unit_bench
   import intc_pkg::*;
   ;
   localparam logic [15:0] VEC [6] = '{16'h0003, 16'h000b, 16'h0013,
                                       16'h001b, 16'h0023, 16'h002b};
   localparam logic [2:0] SRCK [8] = '{0, 1, 2, 3, 4, 5, 4, 5};
   localparam logic [7:0] EXPB [8] = '{0, 0, 0, 0, 8'h01, 8'h40, 8'h02, 8'h80};
   localparam logic [5:0] EVK [8] = '{0, 6'h01, 0, 6'h02, 6'h10, 6'h08,
                                      6'h20, 6'h04};
   logic        clk;
   logic        reset;
   sfr_req_t    sfr_req;
   logic        pin0;
   logic        pin1;
   logic [5:0]  ev;
   logic        return_from_interrupt_instr_cmd;
   logic [2:0]  instr_len;
   logic        last_cycle;
   logic        return_from_interrupt_instr_exec;
   logic [7:0]  sfr_rdata_q;
   logic        call_req_q;
   call_t       call_q;
   logic        call_busy_q;
   logic [3:0]  in_progress_q;
   logic        lc_q;
   int          err_total;
   int          cmp_count;
   int          n;

   four_level_vectored_interrupt_unit i_four_level_vectored_interrupt_unit (
      .clk(clk), .reset(reset), .sfr_req(sfr_req),
      .ext0_request_pin(pin0), .ext1_request_pin(pin1),
      .timer0_overflow(ev[0]), .timer1_overflow(ev[1]),
      .timer2_overflow(ev[2]), .timer2_external_event(ev[3]),
      .serial_rx_event(ev[4]), .serial_tx_event(ev[5]),
      .last_cycle(last_cycle), .return_from_interrupt_instr_exec(return_from_interrupt_instr_exec),
      .sfr_rdata_q(sfr_rdata_q), .call_req_q(call_req_q), .call_q(call_q),
      .call_busy_q(call_busy_q), .in_progress_q(in_progress_q));

   cpu_seq_model i_cpu_seq_model (
      .clk(clk), .reset(reset), .instr_len(instr_len), .return_from_interrupt_instr_cmd(return_from_interrupt_instr_cmd),
      .call_busy_q(call_busy_q), .last_cycle(last_cycle),
      .return_from_interrupt_instr_exec(return_from_interrupt_instr_exec));

   // ---------------------------------------------------------------
   // clock, monitor and tasks
   // ---------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   always @(posedge clk) begin
      if (call_req_q === 1'b1) begin
         `CHK(lc_q, 1'b1)
      end
      lc_q <= last_cycle;
   end

   task automatic conclude();
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic tick(input int c);
      repeat (c) @(posedge clk);
      #1;
   endtask

   task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
      sfr_req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      tick(1);
      sfr_req.wr = 1'b0;
      tick(1);
   endtask

   task automatic sfr_chk(input logic [7:0] a, input logic [7:0] e);
      sfr_req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      tick(1);
      `CHK(sfr_rdata_q, e)
      sfr_req.rd = 1'b0;
      tick(1);
   endtask

   task automatic wait_call(input logic [2:0] s, input logic [1:0] l);
      n = 0;
      while (call_req_q !== 1'b1 && n < 600) begin
         tick(1);
         n++;
      end
      if (n >= 600) begin
         err_total++;
         $display("CHECK FAILED t=%0t no call seen", $time);
         conclude();
      end
      `CHK(call_q.vector, VEC[s])
      `CHK(call_q.source, s)
      `CHK(call_q.level, l)
      tick(23);
      `CHK(call_busy_q, 1'b1)
      tick(1);
      `CHK(call_busy_q, 1'b0)
   endtask

   task automatic no_call(input int c);
      logic seen;
      seen = 1'b0;
      repeat (c) begin
         tick(1);
         seen = seen | (call_req_q === 1'b1);
      end
      `CHK(seen, 1'b0)
   endtask

   task automatic return_from_interrupt_instr(input logic [3:0] e);
      int k;
      return_from_interrupt_instr_cmd = 1'b1;
      tick(1);
      return_from_interrupt_instr_cmd = 1'b0;
      for (k = 0; k < 200 && return_from_interrupt_instr_exec !== 1'b1; k++) begin
         tick(1);
      end
      if (k >= 200) begin
         err_total++;
         $display("CHECK FAILED t=%0t no return seen", $time);
         conclude();
      end
      tick(1);
      `CHK(in_progress_q, e)
   endtask

   task automatic raise(input int k);
      if (k == 0 || k == 2) begin
         pin0 = (k != 0);
         pin1 = (k != 2);
         tick(14);
         pin0 = 1'b1;
         pin1 = 1'b1;
      end else begin
         ev = EVK[k];
         tick(1);
         ev = 6'h00;
      end
   endtask

   // ---------------------------------------------------------------
   // test sequence
   // ---------------------------------------------------------------
   initial begin
      reset = 1'b1;
      sfr_req = '0;
      pin0 = 1'b1;
      pin1 = 1'b1;
      ev = 6'h00;
      return_from_interrupt_instr_cmd = 1'b0;
      instr_len = 3'h1;
      lc_q = 1'b0;
      err_total = 0;
      cmp_count = 0;
      repeat (8) @(posedge clk);
      #1;
      reset = 1'b0;
      sfr_chk(PRIO_HIGH_ADDR, 8'h00);
      sfr_chk(ENABLE_ADDR, ENABLE_RESET);
      sfr_wr(PRIO_HIGH_ADDR, 8'hff);
      sfr_chk(PRIO_HIGH_ADDR, 8'h3f);
      sfr_chk(8'h80, 8'h00);
      sfr_wr(PRIO_HIGH_ADDR, 8'h00);
      $display("test registers done");
      sfr_wr(FLAGS_A_ADDR, 8'h05);
      sfr_wr(ENABLE_ADDR, 8'hbf);
      for (int k = 0; k < 8; k++) begin
         raise(k);
         wait_call(SRCK[k], 2'h0);
         `CHK(in_progress_q, 4'h1)
         sfr_chk(FLAGS_A_ADDR, 8'h05);
         sfr_chk(FLAGS_B_ADDR, EXPB[k]);
         sfr_wr(FLAGS_B_ADDR, 8'h00);
         return_from_interrupt_instr(4'h0);
      end
      $display("test vectors done");
      sfr_wr(FLAGS_A_ADDR, 8'h00);
      sfr_wr(ENABLE_ADDR, 8'h81);
      tick(30);
      pin0 = 1'b0;
      wait_call(3'h0, 2'h0);
      `CHK((n + 24 > 36) && (n + 24 < 108), 1'b1)
      sfr_chk(FLAGS_A_ADDR, 8'h02);
      pin0 = 1'b1;
      tick(30);
      return_from_interrupt_instr(4'h0);
      $display("test latency done");
      sfr_wr(ENABLE_ADDR, 8'h80);
      pin1 = 1'b0;
      tick(30);
      pin1 = 1'b1;
      tick(30);
      sfr_wr(ENABLE_ADDR, 8'h84);
      no_call(48);
      sfr_wr(FLAGS_A_ADDR, 8'h20);
      sfr_wr(ENABLE_ADDR, 8'h3f);
      no_call(48);
      sfr_wr(ENABLE_ADDR, 8'hbd);
      no_call(48);
      sfr_wr(ENABLE_ADDR, 8'h82);
      wait_call(3'h1, 2'h0);
      return_from_interrupt_instr(4'h0);
      $display("test gating done");
      instr_len = 3'h4;
      sfr_wr(ENABLE_ADDR, 8'hbf);
      sfr_wr(FLAGS_A_ADDR, 8'ha5);
      sfr_wr(FLAGS_B_ADDR, 8'h01);
      wait_call(3'h1, 2'h0);
      sfr_wr(PRIO_LOW_ADDR, 8'h10);
      wait_call(3'h4, 2'h1);
      `CHK(in_progress_q, 4'h3)
      sfr_wr(PRIO_HIGH_ADDR, 8'h08);
      wait_call(3'h3, 2'h2);
      `CHK(in_progress_q, 4'h7)
      no_call(60);
      sfr_wr(PRIO_LOW_ADDR, 8'h00);
      sfr_wr(PRIO_HIGH_ADDR, 8'h18);
      no_call(60);
      return_from_interrupt_instr(4'h3);
      wait_call(3'h4, 2'h2);
      `CHK(in_progress_q, 4'h7)
      sfr_wr(FLAGS_B_ADDR, 8'h00);
      return_from_interrupt_instr(4'h3);
      return_from_interrupt_instr(4'h1);
      return_from_interrupt_instr(4'h0);
      $display("test nesting done");
      conclude();
   end
endmodule // four_level_vectored_interrupt_unit_bench
`default_nettype wire

// >>> src/four_level_vectored_interrupt_unit.sv
// four-level vectored interrupt unit with flags, enables and priorities
//
// Behaviour
// - level is high bit over low bit
// - fixed polling order breaks same-level ties
// - sample flags at STATE5_PHASE2, poll at PHASE_LAST of the same cycle
// - equal or higher level in progress blocks
// - vector only in instruction's final cycle
// - return or enable/priority write delays one instruction
// - denied requests are not remembered
// - acknowledge by forced call, status word unsaved
// - fixed vector per source, eight bytes apart
// - vectoring clears edge and timer0/1 flags only
// - interrupt return clears current in-progress level
// - plain return leaves in-progress level set
// - pins inverted and latched at STATE5_PHASE2
// - timer2 overflow set STATE2_PHASE2, polled same cycle
// - forced call lasts two machine cycles
// - single-source latency between three and nine
// - global enable gates every source enable
// - trigger select one edge, zero level
// - serial and timer2 requests are ORs
// - software flag writes act like hardware
`timescale 1ns/100ps
`default_nettype none
module four_level_vectored_interrupt_unit
   import intc_pkg::*;
(
   input  wire logic     clk,
   input  wire logic     reset,
   input  wire sfr_req_t sfr_req,
   input  wire logic     ext0_request_pin,
   input  wire logic     ext1_request_pin,
   input  wire logic     timer0_overflow,
   input  wire logic     timer1_overflow,
   input  wire logic     timer2_overflow,
   input  wire logic     timer2_external_event,
   input  wire logic     serial_rx_event,
   input  wire logic     serial_tx_event,
   input  wire logic     last_cycle,
   input  wire logic     return_from_interrupt_instr_exec,
   output logic [7:0]    sfr_rdata_q,
   output logic          call_req_q,
   output call_t         call_q,
   output logic          call_busy_q,
   output logic [3:0]    in_progress_q
);

   typedef enum logic {ST_IDLE, ST_CALL} call_state_t;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [3:0]  phase_q;
   logic [7:0]  enable_q;
   logic [5:0]  prio_low_q;
   logic [5:0]  prio_high_q;
   logic [1:0]  trig_q;
   logic [1:0]  ext_flag_q;
   logic [1:0]  pin_prev_q;
   logic [1:0]  tflag_q;
   logic        rx_q;
   logic        tx_q;
   logic        t2e_q;
   logic        t2o_q;
   logic [5:0]  pend_q;
   logic [5:0]  sample_q;
   logic        sensitive_q;
   call_state_t state_q;
   call_state_t state_d;
   logic [1:0]  call_left_q;

   // ----------------------------------------------------------------
   // phase decode and register decode
   // ----------------------------------------------------------------
   wire logic       s5     = (phase_q == PHASE_STATE5_PHASE2);
   wire logic       s2     = (phase_q == PHASE_STATE2_PHASE2);
   wire logic       mc_end = (phase_q == PHASE_LAST);
   wire logic [7:0] wd     = sfr_req.wdata;
   wire logic       wr_en  = sfr_req.wr && (sfr_req.addr == ENABLE_ADDR);
   wire logic       wr_pl  = sfr_req.wr && (sfr_req.addr == PRIO_LOW_ADDR);
   wire logic       wr_ph  = sfr_req.wr && (sfr_req.addr == PRIO_HIGH_ADDR);
   wire logic       wr_fa  = sfr_req.wr && (sfr_req.addr == FLAGS_A_ADDR);
   wire logic       wr_fb  = sfr_req.wr && (sfr_req.addr == FLAGS_B_ADDR);

   // ----------------------------------------------------------------
   // arbitration and call decision
   // ----------------------------------------------------------------
   wire logic [5:0] gated;
   wire logic       grant_valid;
   wire logic [2:0] grant_src;
   wire logic [1:0] grant_level;
   wire logic       take;
   wire logic [5:0] vec_clr;
   wire logic [3:0] return_from_interrupt_instr_clr;

   assign gated = sample_q & enable_q[5:0] &
                  {6{enable_q[GLOBAL_EN_BIT]}};

   intc_level_arbiter u_arb (
      .req         (gated),
      .prio_high   (prio_high_q),
      .prio_low    (prio_low_q),
      .in_progress (in_progress_q),
      .grant_valid (grant_valid),
      .grant_src   (grant_src),
      .grant_level (grant_level)
   );

   assign take = mc_end && (state_q == ST_IDLE) && grant_valid &&
                 last_cycle && !sensitive_q;
   assign vec_clr  = take ? (6'h01 << grant_src) : 6'h00;
   assign return_from_interrupt_instr_clr = (return_from_interrupt_instr_exec && (|in_progress_q)) ?
                     (4'h1 << highest4(in_progress_q)) : 4'h0;

   // ----------------------------------------------------------------
   // request flags
   // ----------------------------------------------------------------
   wire logic [1:0] pin_low  = {~ext1_request_pin, ~ext0_request_pin};
   wire logic [1:0] edge_set = {2{s5}} & pin_low & ~pin_prev_q;
   wire logic [5:0] events   = {timer2_overflow, timer2_external_event,
                                serial_tx_event, serial_rx_event,
                                timer1_overflow, timer0_overflow};
   wire logic [5:0] apply    = {s2, {5{s5}}};
   wire logic [5:0] fire     = apply & pend_q;
   wire logic [5:0] pend_d   = events | (pend_q & ~apply);
   wire logic [1:0] trig_d;
   wire logic [1:0] ext_flag_d;
   wire logic [1:0] tflag_d;

   genvar k;
   generate
      for (k = 0; k < 2; k++) begin : g_pair
         localparam int TB = EXT0_TRIG_BIT + 2 * k;
         localparam int FB = EXT0_FLAG_BIT + 2 * k;
         localparam int TF = T0_FLAG_BIT + 2 * k;
         wire logic ext_base = wr_fa ? wd[FB] : ext_flag_q[k];
         wire logic t_base   = wr_fa ? wd[TF] : tflag_q[k];
         assign trig_d[k] = wr_fa ? wd[TB] : trig_q[k];
         assign ext_flag_d[k] = trig_q[k] ?
            (edge_set[k] | (ext_base & ~vec_clr[2 * k])) :
            (s5 ? pin_low[k] : ext_base);
         assign tflag_d[k] = fire[k] | (t_base & ~vec_clr[2 * k + 1]);
      end
   endgenerate

   wire logic rx_d  = fire[0 + 2] | (wr_fb ? wd[RX_BIT] : rx_q);
   wire logic tx_d  = fire[1 + 2] | (wr_fb ? wd[TX_BIT] : tx_q);
   wire logic t2e_d = fire[4] | (wr_fb ? wd[T2_EXT_BIT] : t2e_q);
   wire logic t2o_d = fire[5] | (wr_fb ? wd[T2_OVF_BIT] : t2o_q);

   wire logic [5:0] req_vec = {t2o_q | t2e_q, rx_q | tx_q, tflag_q[1],
                               ext_flag_q[1], tflag_q[0],
                               ext_flag_q[0]};

   // flags latched at STATE5_PHASE2 are sampled in that same edge
   wire logic [5:0] req_nxt = {t2o_d | t2e_d, rx_d | tx_d, tflag_d[1],
                               ext_flag_d[1], tflag_d[0], ext_flag_d[0]};

   // timer2 overflow joins the samples in its own cycle
   wire logic [5:0] sample_d = s5 ? req_nxt :
      {sample_q[5] | (s2 & pend_q[5]), sample_q[4:0]};

   // ----------------------------------------------------------------
   // in-progress, sensitivity and call sequencing
   // ----------------------------------------------------------------
   wire logic [3:0] in_prog_d = (in_progress_q & ~return_from_interrupt_instr_clr) |
      (take ? (4'h1 << grant_level) : 4'h0);
   wire logic sens_set = return_from_interrupt_instr_exec | wr_en | wr_pl | wr_ph;
   wire logic sensitive_d = sens_set |
      (sensitive_q & ~(mc_end & last_cycle));

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE: begin
            if (take) begin
               state_d = ST_CALL;
            end
         end
         ST_CALL: begin
            if (mc_end && (call_left_q == 2'h1)) begin
               state_d = ST_IDLE;
            end
         end
      endcase
   end

   wire logic [1:0] call_left_d = take ? CALL_CYCLES :
      ((state_q == ST_CALL && mc_end) ? (call_left_q - 2'h1) : call_left_q);

   // ----------------------------------------------------------------
   // read data
   // ----------------------------------------------------------------
   wire logic [7:0] flags_a = {tflag_q[1], 1'b0, tflag_q[0], 1'b0,
                               ext_flag_q[1], trig_q[1],
                               ext_flag_q[0], trig_q[0]};
   wire logic [7:0] flags_b = {t2o_q, t2e_q, 4'h0, tx_q, rx_q};
   wire logic [7:0] rd_mux =
      (sfr_req.addr == ENABLE_ADDR)    ? enable_q :
      (sfr_req.addr == PRIO_LOW_ADDR)  ? {2'h0, prio_low_q} :
      (sfr_req.addr == PRIO_HIGH_ADDR) ? {2'h0, prio_high_q} :
      (sfr_req.addr == FLAGS_A_ADDR)   ? flags_a :
      (sfr_req.addr == FLAGS_B_ADDR)   ? flags_b : 8'h00;

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         phase_q <= 4'h0;
      end else begin
         phase_q <= mc_end ? 4'h0 : (phase_q + 4'h1);
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         enable_q    <= ENABLE_RESET;
         prio_low_q  <= PRIO_RESET;
         prio_high_q <= PRIO_RESET;
         sfr_rdata_q <= 8'h00;
      end else begin
         enable_q    <= wr_en ? (wd & ENABLE_MASK) : enable_q;
         prio_low_q  <= wr_pl ? wd[5:0] : prio_low_q;
         prio_high_q <= wr_ph ? wd[5:0] : prio_high_q;
         sfr_rdata_q <= sfr_req.rd ? rd_mux : 8'h00;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         trig_q     <= 2'h0;
         ext_flag_q <= 2'h0;
         pin_prev_q <= 2'h0;
         tflag_q    <= 2'h0;
         {rx_q, tx_q, t2e_q, t2o_q} <= 4'h0;
         pend_q     <= 6'h00;
         sample_q   <= 6'h00;
      end else begin
         trig_q     <= trig_d;
         ext_flag_q <= ext_flag_d;
         pin_prev_q <= s5 ? pin_low : pin_prev_q;
         tflag_q    <= tflag_d;
         {rx_q, tx_q, t2e_q, t2o_q} <= {rx_d, tx_d, t2e_d, t2o_d};
         pend_q     <= pend_d;
         sample_q   <= sample_d;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_q       <= ST_IDLE;
         call_left_q   <= 2'h0;
         call_busy_q   <= 1'b0;
         call_req_q    <= 1'b0;
         call_q        <= '0;
         in_progress_q <= 4'h0;
         sensitive_q   <= 1'b0;
      end else begin
         state_q       <= state_d;
         call_left_q   <= call_left_d;
         call_busy_q   <= (state_d == ST_CALL);
         call_req_q    <= take;
         call_q        <= take ? call_t'{vector_of(grant_src), grant_level,
                                         grant_src} : call_q;
         in_progress_q <= in_prog_d;
         sensitive_q   <= sensitive_d;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   final_cycle_a: assert property (call_req_q |-> $past(last_cycle))
      else $error("call issued outside final instruction cycle");
   sensitive_a: assert property (call_req_q |-> !$past(sensitive_q))
      else $error("call issued right after sensitive instruction");
   vector_table_a: assert property (call_req_q |->
      call_q.vector == VECTOR_BASE + {10'h000, call_q.source, 3'h0})
      else $error("wrong vector for source");
   level_block_a: assert property (call_req_q |->
      ($past(in_progress_q) == 4'h0 ||
       call_q.level > highest4($past(in_progress_q))))
      else $error("call taken at blocked level");
   global_gate_a: assert property (call_req_q |->
      $past(enable_q[GLOBAL_EN_BIT]))
      else $error("call taken with global enable clear");
   call_length_a: assert property (call_req_q |->
      call_busy_q [*8] ##16 call_busy_q ##1 !call_busy_q)
      else $error("forced call not two machine cycles");
   edge_clear_a: assert property (call_req_q && call_q.source == 3'h0 &&
      $past(trig_q[0]) && !$past(wr_fa) |-> !ext_flag_q[0])
      else $error("edge request flag not cleared on vectoring");
   t2_keep_a: assert property (call_req_q && call_q.source == 3'h5 &&
      !$past(wr_fb) |-> {t2o_q, t2e_q} == $past({t2o_q, t2e_q}))
      else $error("timer2 flags changed on vectoring");
   return_from_interrupt_instr_level_a: assert property (return_from_interrupt_instr_exec && (|in_progress_q) && !take
      |=> in_progress_q == ($past(in_progress_q) &
          ~(4'h1 << highest4($past(in_progress_q)))))
      else $error("interrupt return did not clear current level");
   fresh_sample_a: assert property (s5 |=> sample_q == req_vec)
      else $error("poll samples not refreshed at STATE5_PHASE2");
   pin_level_a: assert property (s5 && !trig_q[0]
      |=> ext_flag_q[0] == !$past(ext0_request_pin))
      else $error("level request flag does not follow pin");

   call_seen_c: cover property (call_req_q);
   nested_c: cover property (call_req_q && $past(in_progress_q) != 4'h0);
   return_from_interrupt_instr_c: cover property (return_from_interrupt_instr_exec && (|in_progress_q));
   blocked_c: cover property (mc_end && grant_valid && sensitive_q);

endmodule // four_level_vectored_interrupt_unit
`default_nettype wire

// >>> src/intc_level_arbiter.sv
// level and polling-order arbitration of the sampled requests
`timescale 1ns/100ps
`default_nettype none
module intc_level_arbiter
   import intc_pkg::*;
(
   input  wire logic [5:0] req,
   input  wire logic [5:0] prio_high,
   input  wire logic [5:0] prio_low,
   input  wire logic [3:0] in_progress,
   output logic            grant_valid,
   output logic [2:0]      grant_src,
   output logic [1:0]      grant_level
);

   // ----------------------------------------------------------------
   // per-level request masks
   // ----------------------------------------------------------------
   wire logic [5:0] at_level [NUM_LEVELS];
   wire logic [3:0] level_any;
   wire logic [1:0] top_level;
   wire logic [1:0] busy_level;
   wire logic       allowed;

   genvar l, i;
   generate
      for (l = 0; l < NUM_LEVELS; l++) begin : g_level
         for (i = 0; i < NUM_SRC; i++) begin : g_src
            assign at_level[l][i] = req[i] &&
               ({prio_high[i], prio_low[i]} == 2'(l));
         end
         assign level_any[l] = |at_level[l];
      end
   endgenerate

   // ----------------------------------------------------------------
   // winner and blocking
   // ----------------------------------------------------------------
   assign top_level   = highest4(level_any);
   assign busy_level  = highest4(in_progress);
   assign allowed     = !(|in_progress) || (top_level > busy_level);
   assign grant_valid = (|level_any) && allowed;
   assign grant_src   = lowest6(at_level[top_level]);
   assign grant_level = top_level;

endmodule // intc_level_arbiter
`default_nettype wire

// >>> src/intc_pkg.sv
// constants, types and decode functions of the vectored interrupt unit
package intc_pkg;

   // ----------------------------------------------------------------
   // sizes and machine-cycle timing
   // ----------------------------------------------------------------
   localparam int         NUM_SRC     = 6;
   localparam int         NUM_LEVELS  = 4;
   localparam logic [3:0] PHASE_LAST  = 4'hb;
   localparam logic [3:0] PHASE_STATE5_PHASE2  = 4'h9;
   localparam logic [3:0] PHASE_STATE2_PHASE2  = 4'h3;
   localparam logic [1:0] CALL_CYCLES = 2'h2;

   // ----------------------------------------------------------------
   // register addresses and reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] PRIO_HIGH_ADDR = 8'hb7;
   localparam logic [7:0] PRIO_LOW_ADDR  = 8'hb8;
   localparam logic [7:0] ENABLE_ADDR    = 8'ha8;
   localparam logic [7:0] FLAGS_A_ADDR   = 8'h88;
   localparam logic [7:0] FLAGS_B_ADDR   = 8'h98;
   localparam logic [7:0] ENABLE_RESET   = 8'h00;
   localparam logic [5:0] PRIO_RESET     = 6'h00;
   localparam logic [7:0] ENABLE_MASK    = 8'hbf;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int GLOBAL_EN_BIT = 7;
   localparam int EXT0_TRIG_BIT = 0;
   localparam int EXT0_FLAG_BIT = 1;
   localparam int T0_FLAG_BIT   = 5;
   localparam int RX_BIT        = 0;
   localparam int TX_BIT        = 1;
   localparam int T2_EXT_BIT    = 6;
   localparam int T2_OVF_BIT    = 7;

   // ----------------------------------------------------------------
   // vectors
   // ----------------------------------------------------------------
   localparam logic [15:0] VECTOR_BASE = 16'h0003;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } sfr_req_t;

   typedef struct packed {
      logic [15:0] vector;
      logic [1:0]  level;
      logic [2:0]  source;
   } call_t;

   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------
   function automatic logic [1:0] highest4(input logic [3:0] v);
      logic [1:0] r;
      r = 2'h0;
      for (int i = 0; i < NUM_LEVELS; i++) begin
         if (v[i]) begin
            r = 2'(i);
         end
      end
      return r;
   endfunction

   function automatic logic [2:0] lowest6(input logic [5:0] v);
      logic [2:0] r;
      r = 3'h0;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = 3'(i);
         end
      end
      return r;
   endfunction

   function automatic logic [15:0] vector_of(input logic [2:0] src);
      return VECTOR_BASE + {10'h000, src, 3'h0};
   endfunction

endpackage
